/* inc/meter_ctrl_pkg.sv */
// How it works
// - low result byte: 4 LSBs high, rest zero
// - result is upper word joined to low nibble
// - power-up resets port, display, filter, modulator, registers
// - cal inhibit low: calibrate every conversion
// - writing one starts enhanced offset calibration
// - digital power-down stops filter and display drivers
// - analog power-down stops modulator and input buffers
// - peak mode displays highest value only
// - hold freezes displayed reading
// - low battery sets flag and segment
// - minus one displays as minus zero
// - negative values display one count smaller
// - peak stores first result, then larger ones
// - leaving peak mode clears stored peak
// - upper result register: 16 MSBs, read-only
package meter_ctrl_pkg;

  localparam int CMD_BITS  = 8;
  localparam int DATA_BITS = 16;
  localparam int FRAME_BITS = CMD_BITS + DATA_BITS;

  // register indices carried in the low nibble of the command byte
  localparam logic [3:0] REG_CONTROL     = 4'h0;
  localparam logic [3:0] REG_STATUS      = 4'h1;
  localparam logic [3:0] REG_RESULT_HIGH = 4'h2;
  localparam logic [3:0] REG_RESULT_LOW  = 4'h3;
  localparam logic [3:0] REG_PEAK        = 4'h4;
  localparam logic [3:0] REG_DISPLAY     = 4'h5;
  localparam logic [3:0] REG_CUSTOM_OFS  = 4'h6;

  // command byte
  localparam int CMD_READ_POS = 7;

  // control register fields
  localparam int CTL_CAL_INHIBIT_POS = 0;
  localparam int CTL_ENH_CAL_POS     = 1;
  localparam int CTL_DIG_PD_POS      = 2;
  localparam int CTL_ANA_PD_POS      = 3;
  localparam int CTL_PEAK_POS        = 4;
  localparam int CTL_HOLD_POS        = 5;

  // status register fields
  localparam int STS_LOW_SUPPLY_POS = 0;

  localparam logic [15:0] CONTROL_RESET    = 16'h0000;
  localparam logic [15:0] WORD_RESET       = 16'h0000;
  localparam logic [7:0]  RESULT_LOW_RESET = 8'h00;

endpackage

/* rtl/adc_result_display_control.sv */
`timescale 1ns/1ps
module adc_result_display_control (
  input  wire logic        clk,
  input  wire logic        srst,
  input  wire logic        cs_n,
  input  wire logic        sclk,
  input  wire logic        din,
  output logic             dout,
  output logic             dout_oe,
  input  wire logic        conv_valid,
  input  wire logic [19:0] conv_result,
  input  wire logic        low_supply_cmp,
  output logic             offset_cal_en,
  output logic             enhanced_cal_start,
  output logic             filter_enable,
  output logic             lcd_enable,
  output logic             modulator_enable,
  output logic             buffer_enable,
  output logic             display_negative,
  output logic [15:0]      display_magnitude,
  output logic             low_supply_segment,
  output logic [15:0]      custom_offset
);

  // pin synchronisers; stage one feeds stage two only
  // each sclk level must span at least one clock edge or an edge is lost
  logic [1:0] cs_s_r;
  logic [1:0] sclk_s_r;
  logic [1:0] din_s_r;
  logic [1:0] lowb_s_r;
  logic       sclk_d_r;

  always_ff @(posedge clk) begin
    if (srst) begin
      cs_s_r   <= 2'h3;
      sclk_s_r <= 2'h0;
      din_s_r  <= 2'h0;
      lowb_s_r <= 2'h0;
      sclk_d_r <= 1'b0;
    end else begin
      cs_s_r   <= {cs_s_r[0], cs_n};
      sclk_s_r <= {sclk_s_r[0], sclk};
      din_s_r  <= {din_s_r[0], din};
      lowb_s_r <= {lowb_s_r[0], low_supply_cmp};
      sclk_d_r <= sclk_s_r[1];
    end
  end

  wire cs_active = ~cs_s_r[1];
  wire sclk_rise = cs_active & sclk_s_r[1] & ~sclk_d_r;
  wire sclk_fall = cs_active & ~sclk_s_r[1] & sclk_d_r;
  wire serial_in = din_s_r[1];

  // serial frame: command byte then one 16-bit data word, msb first
  logic [4:0]  bit_cnt_r;
  logic [4:0]  bit_cnt_nxt;
  logic [7:0]  cmd_r;
  logic [15:0] wdata_r;
  logic [15:0] rshift_r;
  logic        dout_r;
  logic        dout_oe_r;

  wire       cmd_done  = sclk_rise && (bit_cnt_r == 5'(meter_ctrl_pkg::CMD_BITS - 1));
  wire       word_done = sclk_rise && (bit_cnt_r == 5'(meter_ctrl_pkg::FRAME_BITS - 1));
  wire [7:0] cmd_now   = {cmd_r[6:0], serial_in};
  wire [3:0] addr      = cmd_r[3:0];
  wire       is_read   = cmd_r[meter_ctrl_pkg::CMD_READ_POS];
  wire       wr_commit = word_done && !is_read;
  wire [15:0] wdata_now = {wdata_r[14:0], serial_in};

  assign bit_cnt_nxt = !cs_active ? 5'h00 :
                       word_done  ? 5'h00 :
                       sclk_rise  ? bit_cnt_r + 5'h01 : bit_cnt_r;

  // control and data registers
  logic [15:0] control_r;
  logic [15:0] custom_ofs_r;
  logic [15:0] result_high_r;
  logic [3:0]  result_nib_r;
  logic [15:0] peak_r;
  logic        peak_valid_r;
  logic [15:0] display_r;
  logic        low_flag_r;
  logic        enh_start_r;

  wire cal_inhibit = control_r[meter_ctrl_pkg::CTL_CAL_INHIBIT_POS];
  wire dig_pd      = control_r[meter_ctrl_pkg::CTL_DIG_PD_POS];
  wire ana_pd      = control_r[meter_ctrl_pkg::CTL_ANA_PD_POS];
  wire peak_mode   = control_r[meter_ctrl_pkg::CTL_PEAK_POS];
  wire hold_mode   = control_r[meter_ctrl_pkg::CTL_HOLD_POS];

  wire ctl_wr      = wr_commit && (addr == meter_ctrl_pkg::REG_CONTROL);
  wire ofs_wr      = wr_commit && (addr == meter_ctrl_pkg::REG_CUSTOM_OFS);
  wire enh_trigger = ctl_wr && wdata_now[meter_ctrl_pkg::CTL_ENH_CAL_POS];

  // conversions are dropped while the filter is powered down
  wire        conv_take = conv_valid && !dig_pd;
  wire [15:0] conv_high = conv_result[19:4];
  wire        conv_above_peak = $signed(conv_high) > $signed(peak_r);
  wire        peak_load = peak_mode && conv_take && (!peak_valid_r || conv_above_peak);

  // enhanced-cal bit is a trigger only and never stored
  wire [15:0] ctl_store = wdata_now & ~(16'h0001 << meter_ctrl_pkg::CTL_ENH_CAL_POS);

  always_ff @(posedge clk) begin
    if (srst) begin
      control_r <= meter_ctrl_pkg::CONTROL_RESET;
    end else if (ctl_wr) begin
      control_r <= ctl_store;
    end
  end

  // custom offset is only held here; the subtraction belongs to the filter
  always_ff @(posedge clk) begin
    if (srst) begin
      custom_ofs_r <= meter_ctrl_pkg::WORD_RESET;
    end else if (ofs_wr) begin
      custom_ofs_r <= wdata_now;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      enh_start_r <= 1'b0;
    end else begin
      enh_start_r <= enh_trigger;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      result_high_r <= meter_ctrl_pkg::WORD_RESET;
      result_nib_r  <= 4'h0;
    end else if (conv_take) begin
      result_high_r <= conv_high;
      result_nib_r  <= conv_result[3:0];
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      peak_r       <= meter_ctrl_pkg::WORD_RESET;
      peak_valid_r <= 1'b0;
    end else if (!peak_mode) begin
      peak_r       <= meter_ctrl_pkg::WORD_RESET;
      peak_valid_r <= 1'b0;
    end else if (peak_load) begin
      peak_r       <= conv_high;
      peak_valid_r <= 1'b1;
    end
  end

  // hold wins over peak; the held word is whatever was shown when hold rose
  wire [15:0] display_nxt = hold_mode ? display_r :
                            peak_mode ? (peak_load ? conv_high : peak_r) :
                            conv_take ? conv_high : display_r;

  always_ff @(posedge clk) begin
    if (srst) begin
      display_r <= meter_ctrl_pkg::WORD_RESET;
    end else begin
      display_r <= display_nxt;
    end
  end

  // the comparator is level sensitive; flag follows it
  always_ff @(posedge clk) begin
    if (srst) begin
      low_flag_r <= 1'b0;
    end else begin
      low_flag_r <= lowb_s_r[1];
    end
  end

  // read mux, loaded once the command byte is complete
  wire [15:0]  low_word    = {8'h00, result_nib_r, 4'h0};
  wire [15:0]  status_word = {15'h0000, low_flag_r};
  wire [3:0]   addr_now    = cmd_now[3:0];
  logic [15:0] read_word;

  // unmapped indices read as zero so a stray read is harmless
  always_comb begin
    if (addr_now == meter_ctrl_pkg::REG_CONTROL) begin
      read_word = control_r;
    end else if (addr_now == meter_ctrl_pkg::REG_STATUS) begin
      read_word = status_word;
    end else if (addr_now == meter_ctrl_pkg::REG_RESULT_HIGH) begin
      read_word = result_high_r;
    end else if (addr_now == meter_ctrl_pkg::REG_RESULT_LOW) begin
      read_word = low_word;
    end else if (addr_now == meter_ctrl_pkg::REG_PEAK) begin
      read_word = peak_r;
    end else if (addr_now == meter_ctrl_pkg::REG_DISPLAY) begin
      read_word = display_r;
    end else if (addr_now == meter_ctrl_pkg::REG_CUSTOM_OFS) begin
      read_word = custom_ofs_r;
    end else begin
      read_word = 16'h0000;
    end
  end

  // shift qualifiers; the counter splits the frame into command and data
  wire        cmd_shift   = sclk_rise && (bit_cnt_r < 5'(meter_ctrl_pkg::CMD_BITS));
  wire        data_shift  = sclk_rise && (bit_cnt_r >= 5'(meter_ctrl_pkg::CMD_BITS));
  wire        data_fall   = sclk_fall && (bit_cnt_r >= 5'(meter_ctrl_pkg::CMD_BITS));
  wire [15:0] rshift_load = cmd_now[meter_ctrl_pkg::CMD_READ_POS] ? read_word : 16'h0000;

  always_ff @(posedge clk) begin
    if (srst) begin
      bit_cnt_r <= 5'h00;
    end else begin
      bit_cnt_r <= bit_cnt_nxt;
    end
  end

  // drive enable follows the synchronised select, so it lags the pin
  always_ff @(posedge clk) begin
    if (srst) begin
      dout_oe_r <= 1'b0;
    end else begin
      dout_oe_r <= cs_active;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      cmd_r <= 8'h00;
    end else if (cmd_shift) begin
      cmd_r <= cmd_now;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      wdata_r <= 16'h0000;
    end else if (data_shift) begin
      wdata_r <= wdata_now;
    end
  end

  // read word is captured at the last command rise, so it is a snapshot
  always_ff @(posedge clk) begin
    if (srst) begin
      rshift_r <= 16'h0000;
    end else if (cmd_done) begin
      rshift_r <= rshift_load;
    end else if (data_fall) begin
      rshift_r <= {rshift_r[14:0], 1'b0};
    end
  end

  // data word leaves on falling edges so the host samples on rising
  always_ff @(posedge clk) begin
    if (srst) begin
      dout_r <= 1'b0;
    end else if (!cs_active) begin
      dout_r <= 1'b0;
    end else if (data_fall) begin
      dout_r <= rshift_r[15];
    end
  end

  // display conversion: negative shows ~v, so -1 reads -0
  wire        disp_neg = display_r[15];
  wire [15:0] disp_mag = disp_neg ? ~display_r : display_r;

  always_ff @(posedge clk) begin
    if (srst) begin
      offset_cal_en    <= 1'b0;
      filter_enable    <= 1'b0;
      lcd_enable       <= 1'b0;
      modulator_enable <= 1'b0;
      buffer_enable    <= 1'b0;
    end else begin
      offset_cal_en    <= !cal_inhibit && !ana_pd;
      filter_enable    <= !dig_pd;
      lcd_enable       <= !dig_pd;
      modulator_enable <= !ana_pd;
      buffer_enable    <= !ana_pd;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      display_negative  <= 1'b0;
      display_magnitude <= 16'h0000;
    end else begin
      display_negative  <= disp_neg;
      display_magnitude <= disp_mag;
    end
  end

  // segment lags the status flag by one cycle; both are level, not sticky
  always_ff @(posedge clk) begin
    if (srst) begin
      low_supply_segment <= 1'b0;
    end else begin
      low_supply_segment <= low_flag_r;
    end
  end

  assign dout               = dout_r;
  assign dout_oe            = dout_oe_r;
  assign enhanced_cal_start = enh_start_r;
  assign custom_offset      = custom_ofs_r;

endmodule

/* verif/adc_result_display_control_properties.sv */
`timescale 1ns/1ps
module meter_ctrl_checker (
  input wire logic        clk,
  input wire logic        srst,
  input wire logic        cs_n,
  input wire logic        dout,
  input wire logic        dout_oe,
  input wire logic        conv_valid,
  input wire logic        low_supply_cmp,
  input wire logic        offset_cal_en,
  input wire logic        enhanced_cal_start,
  input wire logic        filter_enable,
  input wire logic        lcd_enable,
  input wire logic        modulator_enable,
  input wire logic        buffer_enable,
  input wire logic [15:0] display_magnitude,
  input wire logic        low_supply_segment
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  AST_RESET_QUIET: assert property (disable iff (1'b0) srst |=>
    !filter_enable && !modulator_enable && !dout_oe && display_magnitude == 16'h0000)
    else $error("outputs not cleared by reset");
  AST_DIG_PAIR: assert property (filter_enable == lcd_enable)
    else $error("filter and lcd enables differ");
  AST_ANA_PAIR: assert property (modulator_enable == buffer_enable)
    else $error("modulator and buffer enables differ");
  AST_CAL_NEEDS_ANALOG: assert property (offset_cal_en |-> modulator_enable)
    else $error("calibration enabled while analog is down");
  AST_ENH_PULSE: assert property (enhanced_cal_start |=> !enhanced_cal_start)
    else $error("enhanced calibration start longer than one cycle");
  AST_LOW_SET: assert property (low_supply_cmp [*4] |=> low_supply_segment)
    else $error("low supply segment missing");
  AST_LOW_CLR: assert property (!low_supply_cmp [*4] |=> !low_supply_segment)
    else $error("low supply segment without cause");
  AST_OE_ON: assert property (!cs_n [*4] |=> dout_oe)
    else $error("dout_oe missing while selected");
  AST_OE_OFF: assert property (cs_n [*4] |=> !dout_oe)
    else $error("dout_oe while deselected");
  AST_DOUT_IDLE: assert property (!dout_oe |-> !dout)
    else $error("dout not zero while idle");
  COV_CONV: cover property (conv_valid);
  COV_ENH: cover property (enhanced_cal_start);
  COV_LOW: cover property ($rose(low_supply_segment));
endmodule
bind adc_result_display_control meter_ctrl_checker i_chk (.clk(clk), .srst(srst),
  .cs_n(cs_n), .dout(dout), .dout_oe(dout_oe), .conv_valid(conv_valid),
  .low_supply_cmp(low_supply_cmp), .offset_cal_en(offset_cal_en),
  .enhanced_cal_start(enhanced_cal_start), .filter_enable(filter_enable),
  .lcd_enable(lcd_enable), .modulator_enable(modulator_enable),
  .buffer_enable(buffer_enable), .display_magnitude(display_magnitude),
  .low_supply_segment(low_supply_segment));

/* verif/serial_host.sv */
`timescale 1ns/1ps
module serial_host (
  input  wire logic clk,
  input  wire logic dout,
  output logic      cs_n,
  output logic      sclk,
  output logic      din
);
  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
    din  = 1'b0;
  end
  // six clocks per sclk level: the sampler needs at least one
  task automatic xfer(input logic [23:0] frame, output logic [15:0] rdata);
    rdata = 16'h0000;
    @(negedge clk) cs_n = 1'b0;
    repeat (4) @(negedge clk);
    for (int i = 23; i >= 0; i--) begin
      din = frame[i];
      repeat (6) @(negedge clk);
      if (i < 16) rdata[i] = dout;
      sclk = 1'b1;
      repeat (6) @(negedge clk);
      sclk = 1'b0;
    end
    repeat (6) @(negedge clk);
    cs_n = 1'b1;
    // released line must not keep showing the last bit
    din = ~din;
    repeat (6) @(negedge clk);
  endtask
endmodule

/* verif/tb_adc_result_display_control.sv */
`timescale 1ns/1ps
module tb_adc_result_display_control;
  logic        clk, srst, cs_n, sclk, din, dout, dout_oe, conv_valid, low_supply_cmp;
  logic        offset_cal_en, enhanced_cal_start, filter_enable, lcd_enable;
  logic        modulator_enable, buffer_enable, display_negative, low_supply_segment;
  logic [19:0] conv_result;
  logic [15:0] display_magnitude, custom_offset, rd;
  int          n_fail = 0, num_checks = 0, n_enh = 0;
  adc_result_display_control i_dut (.clk(clk), .srst(srst), .cs_n(cs_n), .sclk(sclk),
    .din(din), .dout(dout), .dout_oe(dout_oe), .conv_valid(conv_valid),
    .conv_result(conv_result), .low_supply_cmp(low_supply_cmp),
    .offset_cal_en(offset_cal_en), .enhanced_cal_start(enhanced_cal_start),
    .filter_enable(filter_enable), .lcd_enable(lcd_enable),
    .modulator_enable(modulator_enable), .buffer_enable(buffer_enable),
    .display_negative(display_negative), .display_magnitude(display_magnitude),
    .low_supply_segment(low_supply_segment), .custom_offset(custom_offset));
  serial_host i_host (.clk(clk), .dout(dout), .cs_n(cs_n), .sclk(sclk), .din(din));
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  always @(negedge clk) if (enhanced_cal_start === 1'b1) n_enh++;
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [3:0] idx, input logic [15:0] d);
    logic [15:0] ignored;
    i_host.xfer({4'h0, idx, d}, ignored);
  endtask
  task automatic rdreg(input logic [3:0] idx, output logic [15:0] d);
    i_host.xfer({4'h8, idx, 16'h0000}, d);
  endtask
  task automatic conv(input logic [19:0] v);
    @(negedge clk);
    conv_result = v;
    conv_valid  = 1'b1;
    @(negedge clk) conv_valid = 1'b0;
    repeat (4) @(negedge clk);
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    #200000;
    n_fail++;
    tally_and_finish();
  end
  initial begin
    srst = 1'b1;
    conv_valid = 1'b0;
    conv_result = 20'h00000;
    low_supply_cmp = 1'b0;
    repeat (3) @(negedge clk);
    srst = 1'b0;
    repeat (4) @(negedge clk);
    rdreg(meter_ctrl_pkg::REG_CONTROL, rd);
    chk(rd, meter_ctrl_pkg::CONTROL_RESET, "control");
    rdreg(meter_ctrl_pkg::REG_RESULT_LOW, rd);
    chk(rd, 16'h0000, "low after reset");
    chk(16'({filter_enable, lcd_enable, modulator_enable, offset_cal_en}), 16'h000f, "en");
    conv(20'h12345);
    rdreg(meter_ctrl_pkg::REG_RESULT_HIGH, rd);
    chk(rd, 16'h1234, "result high");
    rdreg(meter_ctrl_pkg::REG_RESULT_LOW, rd);
    chk(rd, 16'h0050, "result low");
    conv(20'hfffff);
    chk(display_magnitude, 16'h0000, "minus one");
    chk(16'(display_negative), 16'h0001, "minus sign");
    conv(20'hfff9c);
    chk(display_magnitude, 16'h0006, "negative offset");
    wr(meter_ctrl_pkg::REG_CONTROL, 16'h0010);
    conv(20'h00100);
    conv(20'h00500);
    conv(20'h00200);
    rdreg(meter_ctrl_pkg::REG_PEAK, rd);
    chk(rd, 16'h0050, "peak");
    chk(display_magnitude, 16'h0050, "peak shown");
    wr(meter_ctrl_pkg::REG_CONTROL, 16'h0000);
    rdreg(meter_ctrl_pkg::REG_PEAK, rd);
    chk(rd, 16'h0000, "peak cleared");
    conv(20'h00300);
    wr(meter_ctrl_pkg::REG_CONTROL, 16'h0020);
    conv(20'h00700);
    chk(display_magnitude, 16'h0030, "held");
    rdreg(meter_ctrl_pkg::REG_DISPLAY, rd);
    chk(rd, 16'h0030, "held word");
    wr(meter_ctrl_pkg::REG_CONTROL, 16'h0004);
    chk(16'({filter_enable, lcd_enable, modulator_enable, buffer_enable}), 16'h0003, "dpd");
    conv(20'h00900);
    wr(meter_ctrl_pkg::REG_RESULT_HIGH, 16'hbeef);
    rdreg(meter_ctrl_pkg::REG_RESULT_HIGH, rd);
    chk(rd, 16'h0070, "result frozen");
    wr(meter_ctrl_pkg::REG_CONTROL, 16'h0008);
    chk(16'({filter_enable, modulator_enable, buffer_enable, offset_cal_en}), 16'h0008, "apd");
    wr(meter_ctrl_pkg::REG_CONTROL, 16'h0001);
    chk(16'(offset_cal_en), 16'h0000, "cal inhibit");
    wr(meter_ctrl_pkg::REG_CONTROL, 16'h0002);
    chk(16'(n_enh), 16'h0001, "enhanced start");
    chk(16'(offset_cal_en), 16'h0001, "cal every conv");
    rdreg(meter_ctrl_pkg::REG_CONTROL, rd);
    chk(rd, 16'h0000, "trigger self clears");
    wr(meter_ctrl_pkg::REG_CUSTOM_OFS, 16'h1a2b);
    chk(custom_offset, 16'h1a2b, "offset out");
    rdreg(meter_ctrl_pkg::REG_CUSTOM_OFS, rd);
    chk(rd, 16'h1a2b, "offset reg");
    low_supply_cmp = 1'b1;
    repeat (6) @(negedge clk);
    chk(16'(low_supply_segment), 16'h0001, "low segment");
    rdreg(meter_ctrl_pkg::REG_STATUS, rd);
    chk(16'(rd[meter_ctrl_pkg::STS_LOW_SUPPLY_POS]), 16'h0001, "low flag");
    rdreg(4'hf, rd);
    chk(rd, 16'h0000, "unmapped");
    tally_and_finish();
  end
endmodule
